// ==== plr_consts.svh ====
`ifndef PLR_CONSTS_SVH
`define PLR_CONSTS_SVH

// reset / power-up value of the stored output
`define PLR_OUT_CLEAR 1'b0
// priority select encodings
`define PLR_PRIO_RESET_DOM 1'b0
`define PLR_PRIO_SET_DOM 1'b1

`endif

// ==== plr_ctl.sv ====
`timescale 1ns/1ps
module plr_ctl (
  input wire logic clk, // scan clock
  input plr_pkg::plr_in_s req, // levels wanted
  output plr_pkg::plr_in_s ins // levels seen by block
);
  import plr_pkg::*;
  initial ins = '0;
  // levels change just after the scan edge
  always @(posedge clk) begin
    ins <= #1 req;
  end
endmodule

// ==== plr_edge.sv ====
`timescale 1ns/1ps
`include "plr_consts.svh"
module plr_edge (
  input wire logic clk, // scan clock
  input wire logic rst_b, // async reset, active low
  input wire logic level_in, // sampled trigger level
  output logic rise_pulse // one-cycle rising edge
);
  logic prev_reg;
  logic prev_next;

  always_comb begin
    prev_next = level_in;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_reg <= `PLR_OUT_CLEAR;
    end else begin
      prev_reg <= prev_next;
    end
  end

  assign rise_pulse = level_in & ~prev_reg;
endmodule

// ==== plr_pkg.sv ====
package plr_pkg;
  typedef enum logic {
    PLR_RESET_DOMINANT = 1'b0,
    PLR_SET_DOMINANT = 1'b1
  } plr_prio_e;

  typedef struct packed {
    logic set_in;
    logic reset_in;
    logic toggle_trigger;
  } plr_in_s;

  typedef struct packed {
    plr_prio_e priority_select;
    logic retain_en;
    logic toggle_mode;
  } plr_cfg_s;
endpackage

// ==== plr_top.sv ====
`timescale 1ns/1ps
`include "plr_consts.svh"
// Overview of operation
// - latch form: set, reset, or hold
// - latch form: both high clears output
// - retained latch state restored after power loss
// - trigger rising edge toggles when idle
// - trigger ignored while set or reset
// - set alone drives output high
// - reset alone drives output low
// - toggle form: both high follows priority select
// - without retention output powers up cleared
// - retentivity option for toggle element
module plr_top (
  input wire logic CORE_CLK, // scan clock, 40 MHz
  input wire logic RST_B, // async reset, active low
  input wire logic POWER_UP, // pulse: supply restored
  input plr_pkg::plr_in_s INPUTS, // set, reset, trigger levels
  input plr_pkg::plr_cfg_s CFG, // priority, retention, toggle enable
  output logic RELAY_OUT // stored output
);
  import plr_pkg::*;

  // ----------------------------------------
  // trigger edge detection
  // ----------------------------------------
  logic trig_rise;

  plr_edge u_edge (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .level_in(INPUTS.toggle_trigger),
    .rise_pulse(trig_rise)
  );

  // ----------------------------------------
  // input decoding
  // ----------------------------------------
  // both levels low: the only case in which a trigger edge may act
  function automatic logic inputs_idle(plr_in_s lv);
    return !lv.set_in && !lv.reset_in;
  endfunction

  // both levels high: the contested case
  function automatic logic inputs_both(plr_in_s lv);
    return lv.set_in && lv.reset_in;
  endfunction

  // value forced while set and reset are both high
  function automatic logic both_high_value(plr_cfg_s cf);
    logic val;
    val = 1'b0;
    // latch form ignores the priority choice and always clears
    if (cf.toggle_mode && cf.priority_select == PLR_SET_DOMINANT) begin
      val = 1'b1;
    end
    return val;
  endfunction

  // ----------------------------------------
  // output state
  // ----------------------------------------
  logic out_reg;
  logic out_next;
  logic eff_rise;

  // latch form has no trigger and reset dominance
  always_comb begin
    eff_rise = trig_rise & CFG.toggle_mode;
    out_next = out_reg;
    if (POWER_UP && !CFG.retain_en) begin
      // no state kept when option off
      out_next = `PLR_OUT_CLEAR;
    end else if (POWER_UP) begin
      out_next = out_reg;
    end else if (inputs_both(INPUTS)) begin
      out_next = both_high_value(CFG);
    end else if (INPUTS.set_in) begin
      out_next = 1'b1;
    end else if (INPUTS.reset_in) begin
      out_next = 1'b0;
    end else if (eff_rise) begin
      // reached only with set and reset low
      out_next = ~out_reg;
    end else begin
      out_next = out_reg;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      out_reg <= `PLR_OUT_CLEAR;
    end else begin
      out_reg <= out_next;
    end
  end

  assign RELAY_OUT = out_reg;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);

  a_set_drives_high: assert property (
    !POWER_UP && INPUTS.set_in && !INPUTS.reset_in |=> RELAY_OUT)
    else $error("set alone did not drive output high");
  a_reset_drives_low: assert property (
    !POWER_UP && INPUTS.reset_in && !INPUTS.set_in |=> !RELAY_OUT)
    else $error("reset alone did not drive output low");
  a_latch_both_clear: assert property (
    !POWER_UP && !CFG.toggle_mode && INPUTS.set_in && INPUTS.reset_in |=> !RELAY_OUT)
    else $error("latch form did not clear on both high");
  a_prio_both_high: assert property (
    !POWER_UP && CFG.toggle_mode && INPUTS.set_in && INPUTS.reset_in
    |=> RELAY_OUT == $past(CFG.priority_select == PLR_SET_DOMINANT))
    else $error("both high did not follow priority select");
  a_toggle_on_edge: assert property (
    !POWER_UP && CFG.toggle_mode && !INPUTS.set_in && !INPUTS.reset_in
    && INPUTS.toggle_trigger && !$past(INPUTS.toggle_trigger)
    |=> RELAY_OUT != $past(RELAY_OUT))
    else $error("trigger edge did not toggle output");
  a_hold_idle: assert property (
    !POWER_UP && !INPUTS.set_in && !INPUTS.reset_in && !trig_rise
    |=> $stable(RELAY_OUT))
    else $error("output changed while idle");
  a_no_retain_clear: assert property (
    POWER_UP && !CFG.retain_en |=> !RELAY_OUT)
    else $error("output not cleared after power loss");
  a_retain_keeps: assert property (
    POWER_UP && CFG.retain_en |=> $stable(RELAY_OUT))
    else $error("retained output lost after power loss");
  a_trig_blocked: assert property (
    !POWER_UP && INPUTS.set_in && !INPUTS.reset_in && trig_rise |=> RELAY_OUT)
    else $error("trigger acted while set high");
  a_trig_blocked_rst: assert property (
    !POWER_UP && INPUTS.reset_in && !INPUTS.set_in && trig_rise
    |=> !RELAY_OUT)
    else $error("trigger acted while reset high");
  a_trig_both_blocked: assert property (
    !POWER_UP && inputs_both(INPUTS) && trig_rise
    |=> RELAY_OUT == $past(CFG.toggle_mode && CFG.priority_select == PLR_SET_DOMINANT))
    else $error("trigger acted while both high");

  // ----------------------------------------
  // edge qualification checks
  // ----------------------------------------
  a_latch_no_toggle: assert property (
    !POWER_UP && !CFG.toggle_mode && inputs_idle(INPUTS)
    |=> $stable(RELAY_OUT))
    else $error("latch form changed while idle");
  a_single_edge: assert property (
    !POWER_UP && $past(RST_B) && inputs_idle(INPUTS)
    && INPUTS.toggle_trigger && $past(INPUTS.toggle_trigger)
    |=> $stable(RELAY_OUT))
    else $error("held trigger level toggled again");
  a_edge_needs_low: assert property (
    !POWER_UP && CFG.toggle_mode && inputs_idle(INPUTS) && !INPUTS.toggle_trigger
    |=> $stable(RELAY_OUT))
    else $error("output toggled without trigger edge");

  // ----------------------------------------
  // scenario covers
  // ----------------------------------------
  c_toggle: cover property (trig_rise && !INPUTS.set_in && !INPUTS.reset_in
    && CFG.toggle_mode ##1 RELAY_OUT);
  c_set_dom: cover property (INPUTS.set_in && INPUTS.reset_in
    && CFG.priority_select == PLR_SET_DOMINANT && CFG.toggle_mode);
  c_power_retain: cover property (POWER_UP && CFG.retain_en && RELAY_OUT);
  c_power_clear: cover property (POWER_UP && !CFG.retain_en ##1 !RELAY_OUT);
  c_edge_blocked: cover property (trig_rise && !inputs_idle(INPUTS) && CFG.toggle_mode);
endmodule

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
  import plr_pkg::*;
  logic clk = 0;
  logic rst_b = 0;
  logic pwr = 0;
  plr_in_s req = '0;
  plr_in_s ins;
  plr_cfg_s cfg = '0;
  logic q;
  int err_count = 0;
  int n_checks = 0;
  always #12.5 clk = ~clk;
  plr_ctl u_plr_ctl (.clk(clk), .req(req), .ins(ins));
  plr_top u_plr_top (.CORE_CLK(clk), .RST_B(rst_b), .POWER_UP(pwr), .INPUTS(ins),
    .CFG(cfg), .RELAY_OUT(q));
  task automatic check(string name, logic seen, logic exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %b seen %b", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (err_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // one edge for the model, one for the block to sample
  task automatic step(logic s, logic r, logic t, logic exp);
    req = '{s, r, t};
    @(posedge clk);
    @(posedge clk);
    #1 check("relay_out", q, exp);
  endtask
  // an edge passes first so that back-to-back pulses never reassign pwr at once
  task automatic pulse(logic exp);
    @(posedge clk);
    #1 pwr = 1;
    @(posedge clk);
    #1 pwr = 0;
    check("relay_out", q, exp);
  endtask
  task automatic t_latch();
    cfg = '{PLR_SET_DOMINANT, 1'b0, 1'b0};
    step(1, 0, 0, 1); // set
    step(0, 0, 0, 1); // hold
    step(0, 0, 1, 1); // trigger has no effect
    step(0, 1, 0, 0); // reset
    step(1, 0, 0, 1); // set
    step(1, 1, 0, 0); // both clear
  endtask
  task automatic t_toggle();
    cfg = '{PLR_RESET_DOMINANT, 1'b0, 1'b1};
    step(0, 1, 0, 0); // reset alone
    step(0, 0, 1, 1); // rise toggles
    step(0, 0, 1, 1); // level held
    step(0, 0, 0, 1); // fall holds
    step(0, 0, 1, 0); // rise toggles
    step(1, 0, 0, 1); // set alone
    step(1, 0, 1, 1); // set blocks rise
    step(0, 0, 1, 1); // blocked edge not replayed
    step(0, 1, 0, 0); // reset alone
    step(0, 1, 1, 0); // reset blocks rise
    step(0, 0, 1, 0); // blocked edge not replayed
    step(1, 1, 0, 0); // reset dominant
    cfg.priority_select = PLR_SET_DOMINANT;
    step(1, 1, 1, 1); // set dominant
  endtask
  task automatic t_power();
    cfg.retain_en = 1'b1;
    step(0, 0, 0, 1); // idle hold
    pulse(1); // state kept
    cfg.retain_en = 1'b0;
    pulse(0); // state cleared
  endtask
  task automatic t_reset();
    step(1, 0, 0, 1); // set before reset
    req = '{1'b0, 1'b0, 1'b1};
    rst_b = 0;
    #1 check("relay_out", q, 0); // cleared by reset
    repeat (2) @(posedge clk);
    #1 rst_b = 1;
    @(posedge clk);
    #1 check("relay_out", q, 1); // first sample counts as rise
  endtask
  initial begin
    repeat (4) @(posedge clk);
    #1 rst_b = 1;
    check("relay_out", q, 0); // cleared at start
    t_latch();
    t_toggle();
    t_power();
    t_reset();
    finish_test();
  end
  initial begin
    #5000;
    err_count++;
    finish_test();
  end
endmodule
